// *** tlr_pkg.sv ***
package tlr_pkg;
  // Byte addresses of the register words
  localparam logic [7:0] ADDR_TONE2_CTRL_A = 8'h00;
  localparam logic [7:0] ADDR_TONE2_FREQ_LOW = 8'h04;
  localparam logic [7:0] ADDR_TONE1_LEVEL_FREQHI = 8'h08;
  localparam logic [7:0] ADDR_TONE1_FREQ_LOW = 8'h0c;
  localparam logic [7:0] ADDR_LOOPBACK_TEST = 8'h10;
  localparam logic [7:0] ADDR_FACTORY_TEST = 8'h14;
  localparam logic [7:0] ADDR_RINGING_WAVE = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1c;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  // Field positions
  localparam int TONE2_FREQ_BIT8_POS = 0;
  localparam int TONE1_FREQ_BIT8_POS = 0;
  localparam int TONE1_LEVEL_LSB = 1;
  localparam int TONE1_LEVEL_MSB = 7;
  localparam int RING_SEL_POS = 7;
  localparam int CH2_LOOP_LSB = 6;
  localparam int CH1_LOOP_LSB = 4;
  localparam int RING_FREQ_MSB = 5;
  localparam int FACTORY_TEST_MSB = 3;
  localparam logic [1:0] LOOP_NORMAL = 2'h0;
  localparam logic [1:0] LOOP_DIGITAL = 2'h1;
  localparam logic [1:0] LOOP_ANALOG = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    TLR_LB_OFF = 2'b01,
    TLR_LB_ON = 2'b10
  } tlr_unused_t;
  typedef enum logic [2:0] {
    TLR_IDLE = 3'b001,
    TLR_BRESP = 3'b010,
    TLR_RRESP = 3'b100
  } tlr_state_t;
endpackage

// *** tlr_tone_decode.sv ***
`timescale 1ns/100ps
module tlr_tone_decode (
  input wire logic ring_sel,
  input wire logic [6:0] level,
  input wire logic [8:0] freq_code,
  input wire logic [1:0] ch1_loop,
  input wire logic [1:0] ch2_loop,
  output logic tone1_enable,
  output logic [8:0] tone1_freq_div10,
  output logic [5:0] tone1_ring_hz,
  output logic [1:0] ch1_loop_mode,
  output logic [1:0] ch2_loop_mode
);
  always_comb
  begin
    tone1_enable = (level != 7'h00);
    tone1_freq_div10 = ring_sel ? 9'h000 : freq_code;
    tone1_ring_hz = ring_sel ? freq_code[tlr_pkg::RING_FREQ_MSB:0] : 6'h00;
    ch1_loop_mode = (ch1_loop == 2'h3) ? tlr_pkg::LOOP_NORMAL : ch1_loop;
    ch2_loop_mode = (ch2_loop == 2'h3) ? tlr_pkg::LOOP_NORMAL : ch2_loop;
  end
endmodule // tlr_tone_decode

// *** tlr_regs.sv ***
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
// Overview of operation
// - Second tone frequency is nine bit code, frequency over ten, split across two registers.
// - First tone level is seven bits 7..1; bit 0 holds frequency bit 8.
// - Level code equals (dBm0 plus 12.2) times ten, codes 1 to 127.
// - Level code zero disables first tone output whatever the frequency.
// - Ringing select clear decodes full nine bit frequency over ten.
// - Ringing select set ignores frequency bits 8, 7 and 6.
// - Ringing mode uses low six bits directly as hertz, 15 to 50.
// - Two bit loopback selector per channel: normal, digital, analog.
// - Ringing select switches first tone between normal and ringing operation.
module tlr_regs (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [8:0] tone2_freq_div10,
  output logic tone1_enable,
  output logic [6:0] tone1_level,
  output logic tone1_ringing,
  output logic [8:0] tone1_freq_div10,
  output logic [5:0] tone1_ring_hz,
  output logic [1:0] ch1_loop_mode,
  output logic [1:0] ch2_loop_mode,
  output logic [3:0] factory_test_bits
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] tone2_ctrl_a_reg, tone2_ctrl_a_next;
  logic [7:0] tone2_freq_low_reg, tone2_freq_low_next;
  logic [7:0] tone1_level_freqhi_reg, tone1_level_freqhi_next;
  logic [7:0] tone1_freq_low_reg, tone1_freq_low_next;
  logic [7:0] loopback_test_reg, loopback_test_next;
  logic [7:0] ringing_wave_reg, ringing_wave_next;
  logic [7:0] aw_addr_reg, aw_addr_next;
  logic aw_have_reg, aw_have_next;
  logic [7:0] w_data_reg, w_data_next;
  logic w_en_reg, w_en_next;
  logic w_have_reg, w_have_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic do_write;
  logic [8:0] dec_freq;
  logic [6:0] dec_level;
  logic dec_ring;
  logic [5:0] dec_ring_hz;
  logic dec_enable;
  logic [1:0] dec_ch1_loop, dec_ch2_loop;

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data may arrive in either order
  assign s_axi_awready = !aw_have_reg && !bvalid_reg;
  assign s_axi_wready = !w_have_reg && !bvalid_reg;
  assign do_write = aw_have_reg && w_have_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  always_comb
  begin
    aw_addr_next = aw_addr_reg;
    aw_have_next = aw_have_reg;
    w_data_next = w_data_reg;
    w_en_next = w_en_reg;
    w_have_next = w_have_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    tone2_ctrl_a_next = tone2_ctrl_a_reg;
    tone2_freq_low_next = tone2_freq_low_reg;
    tone1_level_freqhi_next = tone1_level_freqhi_reg;
    tone1_freq_low_next = tone1_freq_low_reg;
    loopback_test_next = loopback_test_reg;
    ringing_wave_next = ringing_wave_reg;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_addr_next = s_axi_awaddr;
      aw_have_next = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_data_next = s_axi_wdata[7:0];
      // Registers are one byte wide: only lane 0 carries them
      w_en_next = s_axi_wstrb[0];
      w_have_next = 1'b1;
    end
    if (do_write)
    begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = tlr_pkg::RESP_OKAY;
      case ({aw_addr_reg[7:2], 2'b00})
        tlr_pkg::ADDR_TONE2_CTRL_A:
          if (w_en_reg) tone2_ctrl_a_next = w_data_reg;
        tlr_pkg::ADDR_TONE2_FREQ_LOW:
          if (w_en_reg) tone2_freq_low_next = w_data_reg;
        tlr_pkg::ADDR_TONE1_LEVEL_FREQHI:
          if (w_en_reg) tone1_level_freqhi_next = w_data_reg;
        tlr_pkg::ADDR_TONE1_FREQ_LOW:
          if (w_en_reg) tone1_freq_low_next = w_data_reg;
        tlr_pkg::ADDR_LOOPBACK_TEST:
          if (w_en_reg) loopback_test_next = w_data_reg;
        tlr_pkg::ADDR_RINGING_WAVE:
          if (w_en_reg) ringing_wave_next = w_data_reg;
        // Factory test word: writes dropped, answered okay
        tlr_pkg::ADDR_FACTORY_TEST:
          bresp_next = tlr_pkg::RESP_OKAY;
        default:
          bresp_next = tlr_pkg::RESP_SLVERR;
      endcase
    end
    if (bvalid_reg && s_axi_bready)
    begin
      bvalid_next = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_addr_reg <= 8'h00;
      aw_have_reg <= 1'b0;
      w_data_reg <= 8'h00;
      w_en_reg <= 1'b0;
      w_have_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      tone2_ctrl_a_reg <= tlr_pkg::RESET_VALUE;
      tone2_freq_low_reg <= tlr_pkg::RESET_VALUE;
      tone1_level_freqhi_reg <= tlr_pkg::RESET_VALUE;
      tone1_freq_low_reg <= tlr_pkg::RESET_VALUE;
      loopback_test_reg <= tlr_pkg::RESET_VALUE;
      ringing_wave_reg <= tlr_pkg::RESET_VALUE;
    end
    else
    begin
      aw_addr_reg <= aw_addr_next;
      aw_have_reg <= aw_have_next;
      w_data_reg <= w_data_next;
      w_en_reg <= w_en_next;
      w_have_reg <= w_have_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      tone2_ctrl_a_reg <= tone2_ctrl_a_next;
      tone2_freq_low_reg <= tone2_freq_low_next;
      tone1_level_freqhi_reg <= tone1_level_freqhi_next;
      tone1_freq_low_reg <= tone1_freq_low_next;
      loopback_test_reg <= loopback_test_next;
      ringing_wave_reg <= ringing_wave_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: one read in flight, answer one cycle after address
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

  always_comb
  begin
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_next = 1'b1;
      rresp_next = tlr_pkg::RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        tlr_pkg::ADDR_TONE2_CTRL_A: rdata_next = {24'h000000, tone2_ctrl_a_reg};
        tlr_pkg::ADDR_TONE2_FREQ_LOW: rdata_next = {24'h000000, tone2_freq_low_reg};
        tlr_pkg::ADDR_TONE1_LEVEL_FREQHI: rdata_next = {24'h000000, tone1_level_freqhi_reg};
        tlr_pkg::ADDR_TONE1_FREQ_LOW: rdata_next = {24'h000000, tone1_freq_low_reg};
        tlr_pkg::ADDR_LOOPBACK_TEST: rdata_next = {24'h000000, loopback_test_reg};
        tlr_pkg::ADDR_RINGING_WAVE: rdata_next = {24'h000000, ringing_wave_reg};
        // Factory test word holds nothing and reads zero
        tlr_pkg::ADDR_FACTORY_TEST: rdata_next = 32'h00000000;
        // Decoded state of the block
        tlr_pkg::ADDR_STATUS:
          rdata_next = {11'h000, dec_ch2_loop, dec_ch1_loop, dec_enable, dec_ring, dec_ring_hz, dec_freq};
        default:
        begin
          rdata_next = 32'h00000000;
          rresp_next = tlr_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_reg && s_axi_rready)
    begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rresp_reg <= 2'h0;
      rdata_reg <= 32'h00000000;
    end
    else
    begin
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // level code passed unchanged
  assign dec_level = tone1_level_freqhi_reg[tlr_pkg::TONE1_LEVEL_MSB:tlr_pkg::TONE1_LEVEL_LSB];
  assign dec_ring = ringing_wave_reg[tlr_pkg::RING_SEL_POS];

  tlr_tone_decode u_decode (
    .ring_sel(dec_ring),
    .level(dec_level),
    .freq_code({tone1_level_freqhi_reg[tlr_pkg::TONE1_FREQ_BIT8_POS], tone1_freq_low_reg}),
    .ch1_loop(loopback_test_reg[tlr_pkg::CH1_LOOP_LSB +: 2]),
    .ch2_loop(loopback_test_reg[tlr_pkg::CH2_LOOP_LSB +: 2]),
    .tone1_enable(dec_enable),
    .tone1_freq_div10(dec_freq),
    .tone1_ring_hz(dec_ring_hz),
    .ch1_loop_mode(dec_ch1_loop),
    .ch2_loop_mode(dec_ch2_loop)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output stage: settings leave through flip-flops, one cycle behind the registers, so no decode glitch escapes
  logic [8:0] tone2_freq_out_reg, tone2_freq_out_next;
  logic tone1_enable_out_reg, tone1_enable_out_next;
  logic [6:0] tone1_level_out_reg, tone1_level_out_next;
  logic tone1_ringing_out_reg, tone1_ringing_out_next;
  logic [8:0] tone1_freq_out_reg, tone1_freq_out_next;
  logic [5:0] tone1_ring_hz_out_reg, tone1_ring_hz_out_next;
  logic [1:0] ch1_loop_out_reg, ch1_loop_out_next;
  logic [1:0] ch2_loop_out_reg, ch2_loop_out_next;
  logic [3:0] test_bits_out_reg, test_bits_out_next;

  always_comb
  begin
    tone2_freq_out_next = {tone2_ctrl_a_reg[tlr_pkg::TONE2_FREQ_BIT8_POS], tone2_freq_low_reg};
    tone1_enable_out_next = dec_enable;
    tone1_level_out_next = dec_level;
    tone1_ringing_out_next = dec_ring;
    tone1_freq_out_next = dec_freq;
    tone1_ring_hz_out_next = dec_ring_hz;
    ch1_loop_out_next = dec_ch1_loop;
    ch2_loop_out_next = dec_ch2_loop;
    test_bits_out_next = loopback_test_reg[tlr_pkg::FACTORY_TEST_MSB:0];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tone2_freq_out_reg <= 9'h000;
      tone1_enable_out_reg <= 1'b0;
      tone1_level_out_reg <= 7'h00;
      tone1_ringing_out_reg <= 1'b0;
      tone1_freq_out_reg <= 9'h000;
      tone1_ring_hz_out_reg <= 6'h00;
      ch1_loop_out_reg <= 2'h0;
      ch2_loop_out_reg <= 2'h0;
      test_bits_out_reg <= 4'h0;
    end
    else
    begin
      tone2_freq_out_reg <= tone2_freq_out_next;
      tone1_enable_out_reg <= tone1_enable_out_next;
      tone1_level_out_reg <= tone1_level_out_next;
      tone1_ringing_out_reg <= tone1_ringing_out_next;
      tone1_freq_out_reg <= tone1_freq_out_next;
      tone1_ring_hz_out_reg <= tone1_ring_hz_out_next;
      ch1_loop_out_reg <= ch1_loop_out_next;
      ch2_loop_out_reg <= ch2_loop_out_next;
      test_bits_out_reg <= test_bits_out_next;
    end
  end

  assign tone2_freq_div10 = tone2_freq_out_reg;
  assign tone1_level = tone1_level_out_reg;
  assign tone1_enable = tone1_enable_out_reg;
  assign tone1_ringing = tone1_ringing_out_reg;
  assign tone1_freq_div10 = tone1_freq_out_reg;
  assign tone1_ring_hz = tone1_ring_hz_out_reg;
  assign ch1_loop_mode = ch1_loop_out_reg;
  assign ch2_loop_mode = ch2_loop_out_reg;
  assign factory_test_bits = test_bits_out_reg;
endmodule // tlr_regs

// *** tlr_regs_assertions.sv ***
`timescale 1ns/100ps
module tlr_regs_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tone1_enable,
  input wire logic [6:0] tone1_level,
  input wire logic tone1_ringing,
  input wire logic [8:0] tone1_freq_div10,
  input wire logic [5:0] tone1_ring_hz,
  input wire logic [1:0] ch1_loop_mode,
  input wire logic [1:0] ch2_loop_mode
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////
  a_enable_level: assert property (tone1_enable == (tone1_level != 7'h0))
    else $error("tone enable disagrees with level");
  a_ring_nofreq: assert property (tone1_ringing |-> tone1_freq_div10 == 9'h0)
    else $error("tone frequency shown in ringing mode");
  a_norm_nohz: assert property (!tone1_ringing |-> tone1_ring_hz == 6'h0)
    else $error("ringing hertz shown in normal mode");
  a_loop_three: assert property (ch1_loop_mode != 2'h3 && ch2_loop_mode != 2'h3)
    else $error("loopback code three passed through");
  // Both halves taken together answer two edges later
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:21] == 11'h0)
    else $error("read answer late or upper bits set");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed while waiting");
endmodule // tlr_regs_assertions

// *** tlr_regs_bench.sv ***
`timescale 1ns/100ps
module tlr_regs_bench;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tone1_enable, tone1_ringing;
  logic [7:0] s_axi_awaddr, s_axi_araddr, a, d;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, factory_test_bits;
  logic [1:0] s_axi_bresp, s_axi_rresp, ch1_loop_mode, ch2_loop_mode;
  logic [8:0] tone2_freq_div10, tone1_freq_div10;
  logic [6:0] tone1_level;
  logic [5:0] tone1_ring_hz;
  logic [7:0] m [0:6];
  logic [7:0] wa [0:5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18};
  // codes in band whenever ringing is off, except after 16'h0800 clears level and frequency bit 8
  logic [15:0] dir [$] = {16'h0001, 16'h0454, 16'h0881, 16'h0c2c, 16'h0800, 16'h08ff, 16'h18ff, 16'h0cd4,
    16'h0833, 16'h1040, 16'h1090, 16'h10f0, 16'h0c2c, 16'h1800, 16'h1000};
  int errors = 0;
  int cmp_count = 0;

  tlr_regs tlr_regs_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tone2_freq_div10, .tone1_enable,
    .tone1_level, .tone1_ringing, .tone1_freq_div10, .tone1_ring_hz, .ch1_loop_mode, .ch2_loop_mode,
    .factory_test_bits);

  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////
  function automatic logic [1:0] lp(input logic [1:0] c);
    return (c == 2'h3) ? tlr_pkg::LOOP_NORMAL : c;
  endfunction

  // Model readback, address 0x1c gives the decoded status word
  function automatic logic [31:0] expv(input logic [7:0] ad);
    logic rg;
    logic [8:0] f;
    logic [5:0] h;
    rg = m[6][7];
    f = rg ? 9'h0 : {m[2][0], m[3]};
    h = rg ? m[3][5:0] : 6'h0;
    if (ad == 8'h1c)
      return {11'h0, lp(m[4][7:6]), lp(m[4][5:4]), m[2][7:1] != 7'h0, rg, h, f};
    return (ad < 8'h1c && ad != 8'h14) ? {24'h0, m[ad[4:2]]} : 32'h0;
  endfunction

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task stop_test;
    if (errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Ready is sampled mid-cycle so it reflects the coming edge, not a race with it
  task wr(input logic [7:0] ad, input logic [7:0] dt, input logic [3:0] s, output logic [1:0] r);
    logic ta, tw, tb;
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h0, dt};
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    // Late response ready stalls the answer so the hold checks get exercised
    s_axi_bready <= 1'($urandom);
    do
    begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid && s_axi_bready;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
      else if (!s_axi_bready) s_axi_bready <= 1'($urandom);
    end while (!tb);
  endtask

  task rd(input logic [7:0] ad, output logic [31:0] dt, output logic [1:0] r);
    logic ta, tv;
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'($urandom);
    do
    begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tv = s_axi_rvalid && s_axi_rready;
      dt = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tv) s_axi_rready <= 1'b0;
      else if (!s_axi_rready) s_axi_rready <= 1'($urandom);
    end while (!tv);
  endtask

  task check_outs;
    logic [31:0] st;
    @(negedge aclk);
    st = expv(8'h1c);
    chk("tone2_freq", 32'({m[0][0], m[1]}), 32'(tone2_freq_div10));
    chk("tone1_level", 32'(m[2][7:1]), 32'(tone1_level));
    chk("tone1_freq", 32'(st[8:0]), 32'(tone1_freq_div10));
    chk("ring_hz", 32'(st[14:9]), 32'(tone1_ring_hz));
    chk("ringing", 32'(st[15]), 32'(tone1_ringing));
    chk("enable", 32'(st[16]), 32'(tone1_enable));
    chk("ch1_loop", 32'(st[18:17]), 32'(ch1_loop_mode));
    chk("ch2_loop", 32'(st[20:19]), 32'(ch2_loop_mode));
    chk("test_bits", 32'(m[4][3:0]), 32'(factory_test_bits));
  endtask

  task do_wr(input logic [7:0] ad, input logic [7:0] dt, input logic [3:0] s);
    logic [1:0] r;
    wr(ad, dt, s, r);
    chk("bresp", 32'(ad <= 8'h18 ? tlr_pkg::RESP_OKAY : tlr_pkg::RESP_SLVERR), 32'(r));
    if (s[0] && ad <= 8'h18 && ad != 8'h14) m[ad[4:2]] = dt;
    check_outs();
  endtask

  task do_rd(input logic [7:0] ad);
    logic [31:0] dt;
    logic [1:0] r;
    rd(ad, dt, r);
    chk("rresp", 32'(ad <= 8'h1c ? tlr_pkg::RESP_OKAY : tlr_pkg::RESP_SLVERR), 32'(r));
    chk("rdata", expv(ad), dt);
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge aclk);
    errors++;
    stop_test();
  end

  initial
  begin
    void'($urandom(32'h8aae9317));
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    foreach (m[k]) m[k] = 8'h00;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    check_outs();
    foreach (wa[k]) do_rd(wa[k]);
    foreach (dir[k]) do_wr(dir[k][15:8], dir[k][7:0], 4'hf);
    // Byte lane 0 disabled must leave the register alone
    do_wr(8'h04, 8'h5a, 4'he);
    do_wr(8'h20, 8'h11, 4'hf);
    do_rd(8'h20);
    for (int i = 0; i < 40; i++)
    begin
      a = wa[$urandom_range(5)];
      d = 8'($urandom);
      if (a == 8'h10) d[3:0] = 4'h0;
      // bit 8 set and low byte at most 84 keeps codes in 256..340
      if (a == 8'h00 || a == 8'h08) d[0] = 1'b1;
      if (a == 8'h04 || a == 8'h0c) d = 8'($urandom_range(84));
      do_wr(a, d, 4'($urandom));
      a = 8'($urandom_range(7)) << 2;
      if (a == 8'h14) a = 8'h1c;
      do_rd(a);
    end
    stop_test();
  end
endmodule // tlr_regs_bench

bind tlr_regs tlr_regs_assertions tlr_regs_assertions_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .tone1_enable, .tone1_level, .tone1_ringing, .tone1_freq_div10, .tone1_ring_hz,
  .ch1_loop_mode, .ch2_loop_mode);
